//--- hdl/lss_map.svh
// lss_map.svh: offsets, fields and timing counts of the led startup sequencer
// assumes: included by bare name from the design module and the bench
`ifndef LSS_MAP_SVH
`define LSS_MAP_SVH
// register word addresses (avalon word address)
`define LSS_A_CTRL 3'h0
`define LSS_A_STAT 3'h1
`define LSS_A_IRQ_ST 3'h2
`define LSS_A_IRQ_MSK 3'h3
`define LSS_A_CHAN 3'h4
// ctrl fields
`define LSS_CTRL_EN 0
`define LSS_CTRL_DIM 1
// irq bit positions
`define LSS_IRQ_UVP 0
`define LSS_IRQ_SHORT 1
`define LSS_IRQ_SS_DONE 2
`define LSS_IRQ_SHUTDN 3
`define LSS_IRQ_W 4
// timing counts, in switching-clock cycles
`define LSS_OFF_STD 32768
`define LSS_OFF_LF 8192
`define LSS_DET_STD 3584
`define LSS_DET_LF 832
// soft start time 21.5 ms expressed in ns, converted with the 25 ns clock period
`define LSS_SS_TIME_NS 21500000
`define LSS_CLK_NS 25
`define LSS_SS_CYC (`LSS_SS_TIME_NS / `LSS_CLK_NS)
`endif

//--- hdl/lss_pkg.sv
// lss_pkg.sv: types of the led startup sequencer
// assumes: lss_map.svh is on the include path
package lss_pkg;
   typedef enum logic [3:0] {
      LSS_SLEEP,
      LSS_GATE,
      LSS_WAIT_DIM,
      LSS_DETECT,
      LSS_SHORT_HOLD,
      LSS_SOFT,
      LSS_RUN,
      LSS_LATCHED
   } lss_state_t;
   // per-pin comparator levels from the analog front end
   typedef struct packed {
      logic above_120;
      logic above_230;
      logic above_340;
   } lss_pin_t;
   // power-up fault indications
   typedef struct packed {
      logic out_short;
      logic pin_short;
      logic frequency_set_resistor_bad;
      logic current_set_resistor_bad;
   } lss_pwr_flt_t;
endpackage

//--- hdl/lss_sequencer.sv
// lss_sequencer.sv: startup and fault sequencer for a four-channel led string driver
// assumes: analog indications arrive asynchronously and pass two flops; avalon-mm master on clk_i
//
// What this block does
// - wake only with enable high and supply ok
// - boost and channels wait for dimming high
// - start switching only without power-up faults
// - enable low over 32k cycles (8k with LOW_FREQ) shuts down
// - host may toggle dimming, or tie lines
// - turn on disconnect drive, then check pins
// - detect once gate reached and dimming high
// - wait 3584 (or 832) cycles after threshold
// - classify pins: short, unused, in use
// - unused channels disabled after detection
// - pin short holds off soft start, auto-recovers
// - output below undervoltage level during soft start is a fault
// - undervoltage fault shuts down and latches
// - latch clears on lockout or long enable low
// - latch clears on long dimming low, clock runs
// - clock output active once awake
// - soft start ends on regulation, 93%, timer
`timescale 1ns/1ps
`include "lss_map.svh"
module lss_sequencer #(
   parameter bit LOW_FREQ = 1'b0,
   parameter int NCH = 4,
   parameter int OFF_STD = `LSS_OFF_STD,
   parameter int OFF_LF = `LSS_OFF_LF,
   parameter int SS_CYC = `LSS_SS_CYC
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic [2:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic enable_pin_i,
   input wire logic dimming_pin_i,
   input wire logic supply_lockout_level_i,
   input wire logic gate_reached_i,
   input wire logic out_above_uvp_i,
   input wire logic out_at_93pct_i,
   input wire logic [NCH-1:0] chan_in_reg_i,
   input wire lss_pkg::lss_pwr_flt_t pwr_flt_i,
   input wire lss_pkg::lss_pin_t [NCH-1:0] chan_pin_i,
   output logic clock_output_en_o,
   output logic gate_drive_o,
   output logic boost_en_o,
   output logic soft_start_o,
   output logic [NCH-1:0] chan_en_o,
   output logic output_undervoltage_fault_o,
   output logic irq_o
);
   localparam int OFF_CYC = LOW_FREQ ? OFF_LF : OFF_STD;
   localparam int DET_CYC = LOW_FREQ ? `LSS_DET_LF : `LSS_DET_STD;
   localparam int W_IN = 8 + 3 * NCH;
   // one timer serves detection and soft start, so it must hold the larger count
   localparam int W_SS = $clog2((SS_CYC > DET_CYC ? SS_CYC : DET_CYC) + 1);

   ////////////////////////////////////////////////////////////////
   // input synchronisers
   logic [W_IN-1:0] raw_w;
   logic [W_IN-1:0] s1_r;
   logic [W_IN-1:0] s2_r;
   assign raw_w = {enable_pin_i, dimming_pin_i, supply_lockout_level_i, gate_reached_i,
                   out_above_uvp_i, out_at_93pct_i, |pwr_flt_i, 1'b0, chan_pin_i};
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         s1_r <= '0;
         s2_r <= '0;
      end
      else
      begin
         s1_r <= raw_w;
         s2_r <= s1_r;
      end
   end
   logic [NCH-1:0] reg_s1_r;
   logic [NCH-1:0] reg_s2_r;
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         reg_s1_r <= '0;
         reg_s2_r <= '0;
      end
      else
      begin
         reg_s1_r <= chan_in_reg_i;
         reg_s2_r <= reg_s1_r;
      end
   end

   ////////////////////////////////////////////////////////////////
   // registers reachable by software; ctrl bits are or'ed with pins
   logic [1:0] ctrl_r;
   logic [`LSS_IRQ_W-1:0] irq_st_r;
   logic [`LSS_IRQ_W-1:0] irq_msk_r;
   wire en_w = s2_r[W_IN-1] | ctrl_r[`LSS_CTRL_EN];
   wire dim_w = s2_r[W_IN-2] | ctrl_r[`LSS_CTRL_DIM];
   wire sup_ok_w = s2_r[W_IN-3];
   wire gate_ok_w = s2_r[W_IN-4];
   wire out_ok_w = s2_r[W_IN-5];
   wire out93_w = s2_r[W_IN-6];
   wire pwr_flt_w = s2_r[W_IN-7];
   lss_pkg::lss_pin_t [NCH-1:0] pin_w;
   assign pin_w = s2_r[3*NCH-1:0];

   ////////////////////////////////////////////////////////////////
   // long-low counters for enable and dimming
   localparam int W_OFF = $clog2(OFF_CYC + 2);
   logic [W_OFF-1:0] en_lo_cnt_r;
   logic [W_OFF-1:0] dim_lo_cnt_r;
   wire en_long_low_w = en_lo_cnt_r > W_OFF'(OFF_CYC);
   wire dim_long_low_w = dim_lo_cnt_r > W_OFF'(OFF_CYC);
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         en_lo_cnt_r <= '0;
         dim_lo_cnt_r <= '0;
      end
      else
      begin
         en_lo_cnt_r <= en_w ? '0 : (en_long_low_w ? en_lo_cnt_r : en_lo_cnt_r + 1'b1);
         dim_lo_cnt_r <= (dim_w || !en_w) ? '0 : (dim_long_low_w ? dim_lo_cnt_r : dim_lo_cnt_r + 1'b1);
      end
   end

   ////////////////////////////////////////////////////////////////
   // sequencer
   lss_pkg::lss_state_t st_r;
   lss_pkg::lss_state_t st_nxt;
   logic [W_SS-1:0] tmr_r;
   logic [NCH-1:0] unused_r;
   wire [NCH-1:0] short_w;
   wire [NCH-1:0] unused_w;
   genvar g;
   generate
      for (g = 0; g < NCH; g++)
      begin : g_cls
         assign short_w[g] = !pin_w[g].above_120;
         assign unused_w[g] = pin_w[g].above_230 && !pin_w[g].above_340;
      end
   endgenerate
   wire thr_w = &{pin_w[0].above_120, 1'b1} | (|(~short_w)); // detection threshold seen on any pin
   wire det_done_w = tmr_r == W_SS'(DET_CYC);
   wire any_short_w = |short_w;
   // take the fresh classification on the edge that ends detection, else an unused channel glitches on
   wire [NCH-1:0] used_w = ~((st_r == lss_pkg::LSS_DETECT && det_done_w) ? unused_w : unused_r);
   wire all_reg_w = &(reg_s2_r | unused_r);
   wire ss_end_w = all_reg_w || out93_w || tmr_r >= W_SS'(SS_CYC);
   wire shut_w = en_long_low_w || !sup_ok_w;

   always_comb
   begin
      st_nxt = st_r;
      case (st_r)
         lss_pkg::LSS_SLEEP:
            if (en_w && sup_ok_w) st_nxt = lss_pkg::LSS_GATE;
         lss_pkg::LSS_GATE:
            if (gate_ok_w) st_nxt = lss_pkg::LSS_WAIT_DIM;
         lss_pkg::LSS_WAIT_DIM:
            if (dim_w && gate_ok_w && !pwr_flt_w) st_nxt = lss_pkg::LSS_DETECT;
         lss_pkg::LSS_DETECT:
            if (det_done_w) st_nxt = any_short_w ? lss_pkg::LSS_SHORT_HOLD : lss_pkg::LSS_SOFT;
         lss_pkg::LSS_SHORT_HOLD:
            if (!any_short_w) st_nxt = lss_pkg::LSS_SOFT;
         lss_pkg::LSS_SOFT:
            if (!out_ok_w) st_nxt = lss_pkg::LSS_LATCHED;
            else if (ss_end_w) st_nxt = lss_pkg::LSS_RUN;
         lss_pkg::LSS_RUN:
            st_nxt = lss_pkg::LSS_RUN;
         lss_pkg::LSS_LATCHED:
            if (dim_long_low_w) st_nxt = lss_pkg::LSS_WAIT_DIM;
         default:
            st_nxt = lss_pkg::LSS_SLEEP;
      endcase
      if (shut_w) st_nxt = lss_pkg::LSS_SLEEP;
   end

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         st_r <= lss_pkg::LSS_SLEEP;
      else
         st_r <= st_nxt;
   end

   // timer: detection delay counts only once threshold seen; soft start counts from entry
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         tmr_r <= '0;
      else if (st_nxt != st_r)
         tmr_r <= '0;
      else if ((st_r == lss_pkg::LSS_DETECT && thr_w && !det_done_w) || st_r == lss_pkg::LSS_SOFT)
         tmr_r <= tmr_r + 1'b1;
   end

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         unused_r <= '0;
      else if (st_r == lss_pkg::LSS_DETECT && det_done_w)
         unused_r <= unused_w;
      else if (st_r == lss_pkg::LSS_SLEEP)
         unused_r <= '0;
   end

   ////////////////////////////////////////////////////////////////
   // outputs, all registered
   wire boosting_w = (st_nxt == lss_pkg::LSS_SOFT || st_nxt == lss_pkg::LSS_RUN);
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         clock_output_en_o <= 1'b0;
         gate_drive_o <= 1'b0;
         boost_en_o <= 1'b0;
         soft_start_o <= 1'b0;
         chan_en_o <= '0;
         output_undervoltage_fault_o <= 1'b0;
      end
      else
      begin
         clock_output_en_o <= st_nxt != lss_pkg::LSS_SLEEP;
         gate_drive_o <= st_nxt != lss_pkg::LSS_SLEEP && st_nxt != lss_pkg::LSS_LATCHED;
         // dimming gates current in both phases; host toggles it for brightness
         boost_en_o <= boosting_w && dim_w;
         soft_start_o <= st_nxt == lss_pkg::LSS_SOFT;
         chan_en_o <= (boosting_w && dim_w) ? used_w : '0;
         output_undervoltage_fault_o <= st_nxt == lss_pkg::LSS_LATCHED;
      end
   end

   ////////////////////////////////////////////////////////////////
   // avalon slave: registered answers after one wait cycle
   logic ack_r;
   wire req_w = (avs_read_i || avs_write_i) && !ack_r;
   wire wr_w = avs_write_i && ack_r;
   wire [`LSS_IRQ_W-1:0] ev_w;
   assign ev_w[`LSS_IRQ_UVP] = st_nxt == lss_pkg::LSS_LATCHED && st_r != lss_pkg::LSS_LATCHED;
   assign ev_w[`LSS_IRQ_SHORT] = st_nxt == lss_pkg::LSS_SHORT_HOLD && st_r != lss_pkg::LSS_SHORT_HOLD;
   assign ev_w[`LSS_IRQ_SS_DONE] = st_nxt == lss_pkg::LSS_RUN && st_r == lss_pkg::LSS_SOFT;
   assign ev_w[`LSS_IRQ_SHUTDN] = st_nxt == lss_pkg::LSS_SLEEP && st_r != lss_pkg::LSS_SLEEP;
   wire clr_w = wr_w && avs_address_i == `LSS_A_IRQ_ST && avs_byteenable_i[0];
   logic [31:0] rd_w;
   always_comb
   begin
      case (avs_address_i)
         `LSS_A_CTRL: rd_w = {30'h0, ctrl_r};
         `LSS_A_STAT: rd_w = {28'h0, st_r};
         `LSS_A_IRQ_ST: rd_w = {28'h0, irq_st_r};
         `LSS_A_IRQ_MSK: rd_w = {28'h0, irq_msk_r};
         `LSS_A_CHAN: rd_w = {24'h0, 4'(unused_r), 4'(chan_en_o)};
         default: rd_w = 32'h0;
      endcase
   end
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         ack_r <= 1'b0;
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o <= 32'h0;
         ctrl_r <= 2'h0;
         irq_msk_r <= '0;
         irq_st_r <= '0;
         irq_o <= 1'b0;
      end
      else
      begin
         ack_r <= req_w;
         avs_waitrequest_o <= !req_w;
         if (req_w)
            avs_readdata_o <= rd_w;
         if (wr_w && avs_address_i == `LSS_A_CTRL && avs_byteenable_i[0])
            ctrl_r <= avs_writedata_i[1:0];
         if (wr_w && avs_address_i == `LSS_A_IRQ_MSK && avs_byteenable_i[0])
            irq_msk_r <= avs_writedata_i[`LSS_IRQ_W-1:0];
         // set beats clear in the same cycle
         irq_st_r <= (irq_st_r & ~(clr_w ? avs_writedata_i[`LSS_IRQ_W-1:0] : '0)) | ev_w;
         irq_o <= |(((irq_st_r & ~(clr_w ? avs_writedata_i[`LSS_IRQ_W-1:0] : '0)) | ev_w) & irq_msk_r);
      end
   end

   ////////////////////////////////////////////////////////////////
   // assertions
   wake_guard_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      st_r == lss_pkg::LSS_SLEEP && st_nxt != lss_pkg::LSS_SLEEP |-> en_w && sup_ok_w)
      else $error("woke without enable and supply");
   dim_gate_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      boost_en_o |-> $past(dim_w))
      else $error("boost on without dimming high");
   pwr_check_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      st_r == lss_pkg::LSS_WAIT_DIM && pwr_flt_w |=> st_r != lss_pkg::LSS_DETECT)
      else $error("detection began despite power-up fault");
   long_low_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      en_long_low_w |=> st_r == lss_pkg::LSS_SLEEP)
      else $error("no shutdown after long enable low");
   gate_first_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      st_r == lss_pkg::LSS_GATE && !shut_w |=> gate_drive_o)
      else $error("disconnect drive not on");
   det_start_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      st_r == lss_pkg::LSS_WAIT_DIM && st_nxt == lss_pkg::LSS_DETECT |-> gate_ok_w && dim_w)
      else $error("detection started early");
   det_delay_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      st_r == lss_pkg::LSS_DETECT && st_nxt != lss_pkg::LSS_DETECT && !shut_w |-> tmr_r == W_SS'(DET_CYC))
      else $error("detection delay wrong");
   unused_off_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (chan_en_o & unused_r) == '0)
      else $error("unused channel enabled");
   short_hold_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      st_r == lss_pkg::LSS_SHORT_HOLD && any_short_w |=> !soft_start_o)
      else $error("soft start during pin short");
   uvp_latch_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      st_r == lss_pkg::LSS_SOFT && !out_ok_w && !shut_w |=> output_undervoltage_fault_o && !boost_en_o)
      else $error("undervoltage not latched");
   clk_keep_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      st_r == lss_pkg::LSS_LATCHED && !shut_w |=> clock_output_en_o)
      else $error("clock output stopped while latched");
   ss_cover_c: cover property (@(posedge clk_i) disable iff (!arst_n_i) st_r == lss_pkg::LSS_RUN);
   short_cover_c: cover property (@(posedge clk_i) disable iff (!arst_n_i) st_r == lss_pkg::LSS_SHORT_HOLD);
   latch_cover_c: cover property (@(posedge clk_i) disable iff (!arst_n_i)
      st_r == lss_pkg::LSS_LATCHED ##1 st_r == lss_pkg::LSS_WAIT_DIM);
endmodule

//--- verif/lss_host_model.sv
// lss_host_model.sv: host that drives the enable and dimming lines of the sequencer
// assumes: the bench calls set_lines; lines change just after a rising clock edge
`timescale 1ns/1ps
module lss_host_model #(
   parameter bit TIED = 1'b0
) (
   input wire logic clk_i,
   output logic enable_o,
   output logic dimming_o
);
   logic en_r = 1'b0;
   logic dim_r = 1'b0;
   ////////////////////////////////////////////////////////////////
   // dimming may toggle at will while enable is high
   task automatic set_lines(input logic en, input logic dim);
      @(posedge clk_i);
      en_r <= en;
      dim_r <= dim;
   endtask
   // single-wire mode: one signal serves both lines
   assign enable_o = en_r;
   assign dimming_o = TIED ? en_r : dim_r;
endmodule

//--- verif/lss_sequencer_bench.sv
// lss_sequencer_bench.sv: self-checking bench of the led startup sequencer
// assumes: short long-low count (16) and soft start count; standard detection delay
`timescale 1ns/1ps
`include "lss_map.svh"
module lss_sequencer_bench;
   logic clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic [2:0] adr = 3'h0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdat = 32'h0;
   logic sup = 1'b0;
   logic gate = 1'b0;
   logic uvp_ok = 1'b1;
   logic at93 = 1'b0;
   logic [3:0] inreg = 4'h0;
   lss_pkg::lss_pwr_flt_t pf = '0;
   lss_pkg::lss_pin_t [3:0] pins = {3'b110, 3'b111, 3'b111, 3'b111};
   wire [31:0] rdat;
   wire wreq, en, dim, clk_en, gdrv, boost, ss, fault, irq;
   wire [3:0] chen;
   int n_mismatch = 0;
   int total_checks = 0;
   logic [31:0] q;
   lss_host_model HOST (.clk_i(clk_i), .enable_o(en), .dimming_o(dim));
   lss_sequencer #(.OFF_STD(16), .SS_CYC(50)) DUT (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .avs_address_i(adr), .avs_read_i(rd),
      .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hf),
      .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .enable_pin_i(en),
      .dimming_pin_i(dim), .supply_lockout_level_i(sup), .gate_reached_i(gate),
      .out_above_uvp_i(uvp_ok), .out_at_93pct_i(at93), .chan_in_reg_i(inreg),
      .pwr_flt_i(pf), .chan_pin_i(pins), .clock_output_en_o(clk_en), .gate_drive_o(gdrv),
      .boost_en_o(boost), .soft_start_o(ss), .chan_en_o(chen),
      .output_undervoltage_fault_o(fault), .irq_o(irq));
   initial forever #12.5 clk_i = ~clk_i;
   ////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one avalon transfer; request held until waitrequest is seen low at an edge
   task automatic bus(input logic w, input logic [2:0] ad, input logic [31:0] d, output logic [31:0] r);
      int i;
      @(posedge clk_i);
      adr <= ad;
      wdat <= d;
      rd <= !w;
      wr <= w;
      for (i = 0; i < 50; i++)
      begin
         @(posedge clk_i);
         if (wreq === 1'b0)
            break;
      end
      r = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      if (i == 50)
      begin
         n_mismatch++;
         summarize();
      end
   endtask
   // poll the state register; a bound that runs out ends the run
   task automatic wait_state(input logic [3:0] s, input int lim);
      logic [31:0] r;
      int i;
      for (i = 0; i < lim; i++)
      begin
         bus(1'b0, `LSS_A_STAT, 32'h0, r);
         if (r[3:0] === s)
            break;
      end
      chk("state", r, {28'h0, s});
      if (i == lim)
         summarize();
   endtask
   task automatic power_up();
      HOST.set_lines(1'b1, 1'b0);
      wait_state(lss_pkg::LSS_GATE, 20);
      chk("gate_drive", gdrv, 1);
      chk("clock_out", clk_en, 1);
      gate <= 1'b1;
      wait_state(lss_pkg::LSS_WAIT_DIM, 20);
      chk("boost_off", boost, 0);
      repeat (10) @(posedge clk_i);
      wait_state(lss_pkg::LSS_WAIT_DIM, 1);
   endtask
   ////////////////////////////////////////////////////////////////
   task automatic t_reset();
      chk("waitreq", wreq, 1);
      chk("clock_out", clk_en, 0);
      bus(1'b0, 3'h5, 32'h0, q);
      chk("unmapped", q, 0);
      bus(1'b1, `LSS_A_CTRL, 32'h3, q);
      bus(1'b0, `LSS_A_CTRL, 32'h0, q);
      chk("ctrl", q, 32'h3);
      bus(1'b1, `LSS_A_CTRL, 32'h0, q);
      HOST.set_lines(1'b1, 1'b1);
      repeat (10) @(posedge clk_i);
      wait_state(lss_pkg::LSS_SLEEP, 1);
      HOST.set_lines(1'b0, 1'b0);
      sup <= 1'b1;
      $display("test reset done");
   endtask
   task automatic t_start();
      power_up();
      pf <= 4'h8;
      HOST.set_lines(1'b1, 1'b1);
      repeat (3700) @(posedge clk_i);
      wait_state(lss_pkg::LSS_WAIT_DIM, 1);
      chk("soft_blocked", ss, 0);
      chk("boost_blocked", boost, 0);
      pf <= 4'h0;
      wait_state(lss_pkg::LSS_DETECT, 20);
      repeat (3500) @(posedge clk_i);
      wait_state(lss_pkg::LSS_DETECT, 1);
      wait_state(lss_pkg::LSS_SOFT, 50);
      chk("chan_en", chen, 4'h7);
      at93 <= 1'b1;
      wait_state(lss_pkg::LSS_RUN, 3);
      chk("soft_end", ss, 0);
      at93 <= 1'b0;
      bus(1'b0, `LSS_A_IRQ_ST, 32'h0, q);
      chk("ss_done", q[`LSS_IRQ_SS_DONE], 1);
      bus(1'b1, `LSS_A_IRQ_MSK, 32'h0, q);
      repeat (2) @(posedge clk_i);
      chk("irq_masked", irq, 0);
      bus(1'b1, `LSS_A_IRQ_MSK, 32'hf, q);
      repeat (2) @(posedge clk_i);
      chk("irq_mask", irq, 1);
      bus(1'b1, `LSS_A_IRQ_ST, 32'h4, q);
      bus(1'b0, `LSS_A_IRQ_ST, 32'h0, q);
      chk("w1c", q[`LSS_IRQ_SS_DONE], 0);
      chk("irq_clear", irq, 0);
      $display("test start done");
   endtask
   task automatic t_enable_low();
      HOST.set_lines(1'b0, 1'b1);
      repeat (10) @(posedge clk_i);
      HOST.set_lines(1'b1, 1'b1);
      repeat (6) @(posedge clk_i);
      wait_state(lss_pkg::LSS_RUN, 1);
      HOST.set_lines(1'b0, 1'b0);
      repeat (24) @(posedge clk_i);
      wait_state(lss_pkg::LSS_SLEEP, 1);
      chk("clock_off", clk_en, 0);
      gate <= 1'b0;
      $display("test enable_low done");
   endtask
   task automatic t_short_uvp();
      pins[0] <= 3'b000;
      power_up();
      HOST.set_lines(1'b1, 1'b1);
      wait_state(lss_pkg::LSS_DETECT, 20);
      repeat (3700) @(posedge clk_i);
      wait_state(lss_pkg::LSS_SHORT_HOLD, 1);
      chk("short_soft", ss, 0);
      pins[0] <= 3'b111;
      wait_state(lss_pkg::LSS_SOFT, 50);
      uvp_ok <= 1'b0;
      wait_state(lss_pkg::LSS_LATCHED, 20);
      chk("uvp_fault", fault, 1);
      chk("uvp_boost", boost, 0);
      uvp_ok <= 1'b1;
      HOST.set_lines(1'b1, 1'b0);
      repeat (10) @(posedge clk_i);
      chk("latch_held", fault, 1);
      repeat (14) @(posedge clk_i);
      chk("latch_clr", fault, 0);
      chk("clock_kept", clk_en, 1);
      wait_state(lss_pkg::LSS_WAIT_DIM, 20);
      HOST.set_lines(1'b1, 1'b1);
      wait_state(lss_pkg::LSS_DETECT, 20);
      sup <= 1'b0;
      wait_state(lss_pkg::LSS_SLEEP, 20);
      $display("test short_uvp done");
   endtask
   ////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (16) @(posedge clk_i);
      arst_n_i <= 1'b1;
      t_reset();
      t_start();
      t_enable_low();
      t_short_uvp();
      summarize();
   end
endmodule
